// File: beta_ideality_pkg.sv
// Shared constants for the external diode beta and ideality configuration.
// Assumes an 8-bit register port driven by the serial management bus engine.
package beta_ideality_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] BETA_CFG_ADDR = 8'h25;
   localparam logic [7:0] IDEALITY_ADDR = 8'h27;

   // ==========================================================================
   // Field positions
   localparam int BETA_EN_BIT = 3;
   localparam int BETA_SEL_MSB = 2;
   localparam int IDEAL_MSB = 5;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] BETA_CFG_RST = 8'h08;
   localparam logic [7:0] IDEALITY_RST = 8'h12;

   // ==========================================================================
   // Beta codes
   localparam logic [2:0] BETA_OFF_CODE = 3'h7;

   // ==========================================================================
   // Ideality table, factor in units of 0.0001
   localparam logic [5:0] IDEAL_FIRST = 6'h08;
   localparam logic [5:0] IDEAL_LAST = 6'h37;
   localparam int IDEAL_ENTRIES = 48;
   localparam int IDEAL_OFS_W = 10;
   localparam logic [15:0] DIODE_BASE = 16'h26DD;
   localparam logic [15:0] BJT_SHIFT = 16'h0050;
   localparam logic [15:0] FACTOR_UNITY = 16'h2710;

endpackage

// File: ideality_rom.sv
// Ideality code to correction factor lookup with a registered output.
// Assumes code and model select come from logic on the same clock.
`timescale 1ns/100ps

module ideality_rom #(
   parameter int FACTOR_W = 16
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [5:0] code,
   input wire logic model_bjt,
   output logic [FACTOR_W-1:0] factor_q
);

   // ==========================================================================
   // Offsets above the first diode factor, entry 0 for code 08h.
   localparam logic [beta_ideality_pkg::IDEAL_ENTRIES*10-1:0] OFS_TABLE = {
      10'h269, 10'h25C, 10'h24F, 10'h242, 10'h235, 10'h228, 10'h21B, 10'h20E,
      10'h201, 10'h1F4, 10'h1E7, 10'h1DA, 10'h1CD, 10'h1C0, 10'h1B3, 10'h1A6,
      10'h199, 10'h18C, 10'h17F, 10'h172, 10'h165, 10'h158, 10'h14B, 10'h13E,
      10'h130, 10'h122, 10'h115, 10'h107, 10'h0FB, 10'h0EC, 10'h0DF, 10'h0D2,
      10'h0C5, 10'h0B8, 10'h0AA, 10'h09D, 10'h090, 10'h083, 10'h075, 10'h068,
      10'h05B, 10'h04E, 10'h041, 10'h034, 10'h027, 10'h01A, 10'h00D, 10'h000
   };

   initial begin
      if (FACTOR_W < 16) begin
         $error("ideality_rom: FACTOR_W must be at least 16");
      end
   end

   // ==========================================================================
   // Codes outside the table clamp to its nearest end.
   wire logic [5:0] clamped = (code < beta_ideality_pkg::IDEAL_FIRST) ?
      beta_ideality_pkg::IDEAL_FIRST :
      (code > beta_ideality_pkg::IDEAL_LAST) ?
      beta_ideality_pkg::IDEAL_LAST : code;
   wire logic [5:0] index = clamped - beta_ideality_pkg::IDEAL_FIRST;
   wire logic [9:0] offset = OFS_TABLE[index*10 +: 10];
   wire logic [15:0] diode_val = beta_ideality_pkg::DIODE_BASE +
      {6'h00, offset};
   wire logic [15:0] model_val = model_bjt ?
      diode_val - beta_ideality_pkg::BJT_SHIFT : diode_val;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         factor_q <= '0;
      end else begin
         factor_q <= FACTOR_W'(model_val);
      end
   end

endmodule

// File: beta_ideality_cfg.sv
// Beta compensation mode and ideality code registers of the external channel.
// Assumes a same-clock register port from the serial bus engine and a
// conversion-start pulse plus detected beta code from the measurement side.
`timescale 1ns/100ps

module beta_ideality_cfg #(
   parameter int FACTOR_W = 16
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_q,
   input wire logic conv_start,
   input wire logic [2:0] detect_beta,
   input wire logic model_bjt,
   output logic [2:0] beta_code,
   output logic beta_comp_off,
   output logic beta_auto,
   output logic [5:0] ideality_code,
   output logic [FACTOR_W-1:0] ideality_factor
);

   // ==========================================================================
   // Register state
   logic auto_en_q;
   logic auto_en_d;
   logic [2:0] beta_sel_q;
   logic [2:0] beta_sel_d;
   logic [5:0] ideal_q;
   logic [5:0] ideal_d;
   logic [7:0] rdata_d;

   // ==========================================================================
   // Address decode
   wire logic hit_beta = reg_addr == beta_ideality_pkg::BETA_CFG_ADDR;
   wire logic hit_ideal = reg_addr == beta_ideality_pkg::IDEALITY_ADDR;
   wire logic wr_beta = reg_wr && hit_beta;
   wire logic wr_ideal = reg_wr && hit_ideal;
   wire logic auto_latch = conv_start && auto_en_q;
   wire logic manual_wr = wr_beta && !auto_en_q;
   wire logic [7:0] beta_view = {4'h0, auto_en_q, beta_sel_q};
   wire logic [7:0] ideal_view = {2'h0, ideal_q};

   // ==========================================================================
   // Next-state selection
   assign auto_en_d = wr_beta ?
      reg_wdata[beta_ideality_pkg::BETA_EN_BIT] : auto_en_q;
   assign beta_sel_d = auto_latch ? detect_beta :
      manual_wr ? reg_wdata[beta_ideality_pkg::BETA_SEL_MSB:0] :
      beta_sel_q;
   assign ideal_d = wr_ideal ?
      reg_wdata[beta_ideality_pkg::IDEAL_MSB:0] : ideal_q;
   assign rdata_d = !reg_rd ? reg_rdata_q :
      hit_beta ? beta_view : hit_ideal ? ideal_view : 8'h00;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         auto_en_q <= beta_ideality_pkg::BETA_CFG_RST[3];
         beta_sel_q <= beta_ideality_pkg::BETA_CFG_RST[2:0];
         ideal_q <= beta_ideality_pkg::IDEALITY_RST[5:0];
         reg_rdata_q <= 8'h00;
      end else begin
         auto_en_q <= auto_en_d;
         beta_sel_q <= beta_sel_d;
         ideal_q <= ideal_d;
         reg_rdata_q <= rdata_d;
      end
   end

   // ==========================================================================
   // Outputs to the measurement front end
   assign beta_code = beta_sel_q;
   assign beta_comp_off = beta_sel_q == beta_ideality_pkg::BETA_OFF_CODE;
   assign beta_auto = auto_en_q;
   assign ideality_code = ideal_q;

   ideality_rom #(
      .FACTOR_W(FACTOR_W)
   ) u_rom (
      .core_clk(core_clk),
      .nrst(nrst),
      .code(ideal_q),
      .model_bjt(model_bjt),
      .factor_q(ideality_factor)
   );

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   a_auto_latch_code: assert property (
      conv_start && auto_en_q |=> beta_code == $past(detect_beta))
      else $error("autodetected beta not applied");
   a_manual_beta_hold: assert property (
      !auto_en_q && !wr_beta |=> $stable(beta_code))
      else $error("manual beta changed without a write");
   a_auto_write_ignored: assert property (
      auto_en_q && wr_beta && !conv_start |=> $stable(beta_code))
      else $error("beta write took effect during autodetect");
   a_manual_write_applies: assert property (
      !auto_en_q && wr_beta && !conv_start
      |=> beta_code == $past(reg_wdata[2:0]))
      else $error("manual beta write not applied");
   a_beta_read_view: assert property (
      reg_rd && hit_beta
      |=> reg_rdata_q == {4'h0, $past(auto_en_q), $past(beta_code)})
      else $error("beta read does not show current setting");
   a_ideal_write_applies: assert property (
      wr_ideal |=> ideality_code == $past(reg_wdata[5:0]))
      else $error("ideality write not held");
   a_off_code_decode: assert property (
      beta_comp_off == (beta_code == 3'h7))
      else $error("compensation off flag does not match the code");
   a_enable_written: assert property (
      wr_beta |=> beta_auto == $past(reg_wdata[3]))
      else $error("enable bit write not applied");
   a_detect_wins_write: assert property (
      conv_start && auto_en_q && wr_beta |=> beta_code == $past(detect_beta))
      else $error("host write beat the detected beta code");
   a_unmapped_read_zero: assert property (
      reg_rd && !hit_beta && !hit_ideal |=> reg_rdata_q == 8'h00)
      else $error("unmapped read returned nonzero data");
   a_ideal_read_view: assert property (
      reg_rd && hit_ideal
      |=> reg_rdata_q == {2'h0, $past(ideality_code)})
      else $error("ideality read does not show stored code");
   a_rdata_hold: assert property (
      !reg_rd |=> $stable(reg_rdata_q))
      else $error("read data changed without a read");
   a_ideal_hold: assert property (
      !wr_ideal |=> $stable(ideality_code))
      else $error("ideality code changed without a write");
   a_bjt_unity_point: assert property (
      ideality_code == 6'h12 && model_bjt && $stable(ideality_code) &&
      $stable(model_bjt) && $past(nrst) |-> ideality_factor == 16'h2710)
      else $error("transistor model factor at 12h is not unity");
   a_diode_first_point: assert property (
      ideality_code == 6'h08 && !model_bjt && $stable(ideality_code) &&
      $stable(model_bjt) && $past(nrst) |-> ideality_factor == 16'h26DD)
      else $error("diode model factor at 08h is wrong");

   c_auto_update: cover property (conv_start && auto_en_q ##1 1'b1);
   c_manual_write: cover property (wr_beta && !auto_en_q);
   c_ideal_change: cover property (wr_ideal && reg_wdata[5:0] == 6'h15);
   c_comp_off: cover property (beta_comp_off && !auto_en_q);
   c_bjt_unity: cover property (model_bjt && ideality_code == 6'h12);

endmodule

// File: host_model.sv
// Host side model of the register port, one strobe cycle per access.
// Assumes the design takes requests on the rising edge of core_clk.
`timescale 1ns/100ps

module host_model (
   input wire logic core_clk,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata_q
);
   // ==========================================================================
   // Access tasks
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // Released lines carry the inverse so stale values never pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata_q;
   endtask
endmodule

// File: testbench.sv
// Self-checking bench for the beta and ideality configuration registers.
// Assumes the host model drives the register port on falling edges.
`timescale 1ns/100ps

module testbench;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic conv_start = 1'b0;
   logic [2:0] detect_beta = 3'h0;
   logic model_bjt = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rv;
   logic reg_wr, reg_rd, beta_comp_off, beta_auto;
   logic [2:0] beta_code;
   logic [5:0] ideality_code;
   logic [15:0] ideality_factor;
   int errors = 0;
   int checks = 0;
   localparam logic [7:0] BA = beta_ideality_pkg::BETA_CFG_ADDR;
   localparam logic [7:0] IA = beta_ideality_pkg::IDEALITY_ADDR;

   always #5 core_clk = ~core_clk;

   host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q));

   beta_ideality_cfg dut_u (.core_clk(core_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .conv_start(conv_start),
      .detect_beta(detect_beta), .model_bjt(model_bjt),
      .beta_code(beta_code), .beta_comp_off(beta_comp_off),
      .beta_auto(beta_auto), .ideality_code(ideality_code),
      .ideality_factor(ideality_factor));

   // ==========================================================================
   // Helpers
   task automatic chk(input string n, input logic [15:0] s, e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic conv(input logic [2:0] d);
      @(negedge core_clk);
      conv_start = 1'b1;
      detect_beta = d;
      @(negedge core_clk);
      conv_start = 1'b0;
      detect_beta = ~d;
   endtask

   task automatic give_verdict();
      if (errors == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #200000;
      errors++;
      give_verdict();
   end

   // ==========================================================================
   // Tests
   initial begin
      repeat (8) @(negedge core_clk);
      nrst = 1'b1;
      chk("auto reset", beta_auto, 16'h0001);
      host_u.rd(BA, rv);
      chk("beta reset", rv, 16'h0008);
      host_u.rd(IA, rv);
      chk("ideal reset", rv, 16'h0012);
      chk("factor 12h", ideality_factor, 16'h2760);
      host_u.rd(8'h26, rv);
      chk("unmapped", rv, 16'h0000);
      host_u.wr(BA, 8'h0B);
      chk("auto ignore", beta_code, 16'h0000);
      conv(3'h5);
      chk("auto code", beta_code, 16'h0005);
      host_u.rd(BA, rv);
      chk("auto view", rv, 16'h000D);
      host_u.wr(BA, 8'hF3);
      chk("enable off", beta_auto, 16'h0000);
      chk("held code", beta_code, 16'h0005);
      for (int c = 0; c < 8; c++) begin
         host_u.wr(BA, 8'(c));
         chk("man code", beta_code, 16'(c));
         chk("comp off", beta_comp_off, 16'(c == 7));
      end
      host_u.wr(BA, 8'hF3);
      conv(3'h6);
      chk("no detect", beta_code, 16'h0003);
      host_u.rd(BA, rv);
      chk("upper zero", rv, 16'h0003);
      host_u.wr(IA, 8'h15);
      @(negedge core_clk);
      chk("ideal code", ideality_code, 16'h0015);
      chk("factor 15h", ideality_factor, 16'h2787);
      model_bjt = 1'b1;
      @(negedge core_clk);
      chk("bjt 15h", ideality_factor, 16'h2737);
      host_u.wr(IA, 8'hFF);
      @(negedge core_clk);
      chk("bjt clamp", ideality_factor, 16'h28F6);
      host_u.rd(IA, rv);
      chk("ideal width", rv, 16'h003F);
      host_u.wr(IA, 8'h08);
      @(negedge core_clk);
      chk("bjt 08h", ideality_factor, 16'h268D);
      host_u.wr(IA, 8'h12);
      @(negedge core_clk);
      chk("bjt unity", ideality_factor, 16'h2710);
      host_u.wr(BA, 8'h08);
      conv(3'h2);
      chk("re-enable", beta_code, 16'h0002);
      give_verdict();
   end
endmodule
